/* logic/qim_pkg.sv */
// Constants shared by the interrupt routing and bus-mode select logic.
package qim_pkg;
	localparam int QIM_NCH = 4;
	localparam int QIM_NSRC = 4;
	localparam int QIM_AW = 8;

	// Register byte offsets.
	localparam logic [7:0] QIM_OFS_CTRL = 8'h00;
	localparam logic [7:0] QIM_OFS_FIFOCTL = 8'h04;
	localparam logic [7:0] QIM_OFS_SRCEN = 8'h08;
	localparam logic [7:0] QIM_OFS_STATUS = 8'h0c;
	localparam logic [7:0] QIM_OFS_INTSTAT = 8'h10;
	localparam logic [7:0] QIM_OFS_INTMASK = 8'h14;

	// Field positions.
	localparam int QIM_CTRL_OE_LSB = 0;
	localparam int QIM_CTRL_DLAB_LSB = 4;
	localparam int QIM_CTRL_ENH_LSB = 8;
	localparam int QIM_ST_DS_MODE = 0;
	localparam int QIM_ST_FORCE = 1;
	localparam int QIM_ST_DEPTH = 2;
	localparam int QIM_ST_REQ_LSB = 4;
	localparam int QIM_ST_DEEP_LSB = 8;
	localparam int QIM_EV_DEPTH = 4;
	localparam int QIM_NEV = 5;

	// Values after reset.
	localparam logic [11:0] QIM_CTRL_RST = 12'h000;
	localparam logic [3:0] QIM_FIFOCTL_RST = 4'h0;
	localparam logic [15:0] QIM_SRCEN_RST = 16'h0000;
	localparam logic [4:0] QIM_INTMASK_RST = 5'h00;
	// Synchroniser start values at the straps' idle levels: depth high, force low, bus mode high.
	localparam logic [2:0] QIM_STRAP_RST = 3'h5;

	// Bus answers.
	localparam logic [1:0] QIM_RESP_OKAY = 2'h0;
	localparam logic [1:0] QIM_RESP_SLVERR = 2'h2;

	// Number of flip-flops in each pin synchroniser.
	localparam int QIM_SYNC_STAGES = 2;
endpackage : qim_pkg

/* logic/qim_sync.sv */
// Two-stage synchroniser for asynchronous strap pins.
`timescale 1ns/1ns
`default_nettype none
module qim_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// The first stage is read only by the second stage.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else if (ce) begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule : qim_sync
`default_nettype wire

/* logic/qim_irq_mode.sv */
// Per-channel interrupt gating, shared interrupt line and bus-mode and FIFO-depth selection.
`timescale 1ns/1ns
`default_nettype none
// Function
// - In separate-strobe mode each channel has its own interrupt output.
// - Per-channel outputs are three-state and drive high while the channel requests.
// - After reset the per-channel outputs are disabled until enabled.
// - Strap low: each output enabled only while its output-enable bit is set.
// - Strap high: per-channel outputs enabled regardless of the output-enable bit.
// - Data-strobe mode ignores the interrupt-select strap.
// - Data-strobe mode pulls the shared line low if any channel requests.
// - Bus-mode strap high selects separate-strobe, low selects data-strobe.
// - Data-strobe mode wire-ORs the channel requests onto one shared line.
// - FIFO depth is 16 when the depth strap is high, 128 when low.
// - Software can read the live level of the depth strap.
// - Deep-select write while divisor access is set, or enhanced mode, forces 128.
module qim_irq_mode
	import qim_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [qim_pkg::QIM_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [qim_pkg::QIM_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [qim_pkg::QIM_NCH*qim_pkg::QIM_NSRC-1:0] chan_src_pend,
	input wire logic bus_mode_strap,
	input wire logic irq_force_enable_strap,
	input wire logic fifo_depth_strap,
	output logic [qim_pkg::QIM_NCH-1:0] chan_irq_out,
	output logic [qim_pkg::QIM_NCH-1:0] chan_irq_oe,
	output logic shared_irq_n_out,
	output logic shared_irq_oe,
	output logic [qim_pkg::QIM_NCH-1:0] fifo_depth_128,
	output logic ds_mode,
	output logic irq
);
	import qim_pkg::*;

	// Merges written bytes into a stored word under the byte strobes.
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction : wmerge

	logic [2:0] strap_s;
	logic bus_strap_s;
	logic force_strap_s;
	logic depth_strap_s;

	qim_sync #(
		.WIDTH(3),
		.RST_VAL(QIM_STRAP_RST)
	) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.pin_in({fifo_depth_strap, irq_force_enable_strap, bus_mode_strap}),
		.sync_out(strap_s)
	);

	assign bus_strap_s = strap_s[0];
	assign force_strap_s = strap_s[1];
	assign depth_strap_s = strap_s[2];

	logic [11:0] ctrl_q;
	logic [QIM_NCH-1:0] deep_q;
	logic [15:0] srcen_q;
	logic [QIM_NEV-1:0] stat_q;
	logic [QIM_NEV-1:0] mask_q;
	logic [QIM_NCH-1:0] modem_ctrl_irq_out_enable;
	logic [QIM_NCH-1:0] line_ctrl_divisor_latch_access;
	logic [QIM_NCH-1:0] enh_mode;

	assign modem_ctrl_irq_out_enable = ctrl_q[QIM_CTRL_OE_LSB +: QIM_NCH];
	assign line_ctrl_divisor_latch_access = ctrl_q[QIM_CTRL_DLAB_LSB +: QIM_NCH];
	assign enh_mode = ctrl_q[QIM_CTRL_ENH_LSB +: QIM_NCH];

	// Write channel.
	logic aw_full_q;
	logic w_full_q;
	logic [QIM_AW-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic do_wr;
	logic sel_ctrl;
	logic sel_fifo;
	logic sel_srcen;
	logic sel_stat;
	logic sel_mask;
	logic sel_ok;

	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready = !w_full_q && !bvalid_q;
	assign do_wr = ce && aw_full_q && w_full_q && !bvalid_q;

	always_comb begin
		sel_ctrl = 1'b0;
		sel_fifo = 1'b0;
		sel_srcen = 1'b0;
		sel_stat = 1'b0;
		sel_mask = 1'b0;
		sel_ok = 1'b1;
		if (aw_addr_q == QIM_OFS_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (aw_addr_q == QIM_OFS_FIFOCTL) begin
			sel_fifo = 1'b1;
		end else if (aw_addr_q == QIM_OFS_SRCEN) begin
			sel_srcen = 1'b1;
		end else if (aw_addr_q == QIM_OFS_INTSTAT) begin
			sel_stat = 1'b1;
		end else if (aw_addr_q == QIM_OFS_INTMASK) begin
			sel_mask = 1'b1;
		end else if (aw_addr_q == QIM_OFS_STATUS) begin
			sel_ok = 1'b1;
		end else begin
			sel_ok = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			w_full_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_wr) begin
				w_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bvalid_q <= 1'b0;
			bresp_q <= QIM_RESP_OKAY;
		end else if (ce) begin
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q <= sel_ok ? QIM_RESP_OKAY : QIM_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Software-written control registers.
	logic [31:0] wr_word;

	always_comb begin
		wr_word = '0;
		if (sel_ctrl) begin
			wr_word = wmerge({20'h00000, ctrl_q}, w_data_q, w_strb_q);
		end else if (sel_srcen) begin
			wr_word = wmerge({16'h0000, srcen_q}, w_data_q, w_strb_q);
		end else if (sel_mask) begin
			wr_word = wmerge({27'h0000000, mask_q}, w_data_q, w_strb_q);
		end else if (sel_fifo) begin
			wr_word = wmerge({28'h0000000, deep_q}, w_data_q, w_strb_q);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= QIM_CTRL_RST;
			srcen_q <= QIM_SRCEN_RST;
			mask_q <= QIM_INTMASK_RST;
		end else if (do_wr) begin
			if (sel_ctrl) begin
				ctrl_q <= wr_word[11:0];
			end
			if (sel_srcen) begin
				srcen_q <= wr_word[15:0];
			end
			if (sel_mask) begin
				mask_q <= wr_word[QIM_NEV-1:0];
			end
		end
	end

	// The deep-select bit of a channel only takes a write while divisor access is open.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			deep_q <= QIM_FIFOCTL_RST;
		end else if (do_wr && sel_fifo) begin
			for (int c = 0; c < QIM_NCH; c++) begin
				if (line_ctrl_divisor_latch_access[c]) begin
					deep_q[c] <= wr_word[c];
				end
			end
		end
	end

	// Channel requests and pin drive.
	logic [QIM_NCH-1:0] chan_req;
	logic [QIM_NCH-1:0] req_q;
	logic [QIM_NCH-1:0] oe_d;
	logic ds_mode_q;
	logic [QIM_NCH-1:0] irq_out_q;
	logic [QIM_NCH-1:0] irq_oe_q;
	logic shared_oe_q;
	logic [QIM_NCH-1:0] depth128_q;
	logic depth_prev_q;

	always_comb begin
		for (int c = 0; c < QIM_NCH; c++) begin
			chan_req[c] = |(chan_src_pend[c*QIM_NSRC +: QIM_NSRC] &
				srcen_q[c*QIM_NSRC +: QIM_NSRC]);
		end
	end

	always_comb begin
		if (ds_mode_q) begin
			oe_d = '0;
		end else if (force_strap_s) begin
			oe_d = '1;
		end else begin
			oe_d = modem_ctrl_irq_out_enable;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ds_mode_q <= 1'b0;
			irq_out_q <= '0;
			irq_oe_q <= '0;
			shared_oe_q <= 1'b0;
			req_q <= '0;
		end else if (ce) begin
			ds_mode_q <= !bus_strap_s;
			irq_out_q <= chan_req;
			irq_oe_q <= oe_d;
			shared_oe_q <= ds_mode_q && (|chan_req);
			req_q <= chan_req;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			depth128_q <= '0;
			depth_prev_q <= QIM_STRAP_RST[2];
		end else if (ce) begin
			depth128_q <= deep_q | enh_mode | {QIM_NCH{!depth_strap_s}};
			depth_prev_q <= depth_strap_s;
		end
	end

	assign chan_irq_out = irq_out_q;
	assign chan_irq_oe = irq_oe_q;
	assign shared_irq_n_out = 1'b0;
	assign shared_irq_oe = shared_oe_q;
	assign fifo_depth_128 = depth128_q;
	assign ds_mode = ds_mode_q;

	// Sticky events: channel request rises and depth strap changes; set wins over clear.
	logic [QIM_NEV-1:0] ev;
	logic [QIM_NEV-1:0] clr;

	assign ev = {depth_prev_q ^ depth_strap_s, chan_req & ~req_q};
	assign clr = (do_wr && sel_stat) ? (w_strb_q[0] ? w_data_q[QIM_NEV-1:0] : '0) : '0;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stat_q <= '0;
		end else if (ce) begin
			stat_q <= (stat_q & ~clr) | ev;
		end
	end

	assign irq = |(stat_q & mask_q);

	// Read channel.
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [31:0] status_word;

	assign s_axi_arready = !rvalid_q;

	always_comb begin
		status_word = '0;
		status_word[QIM_ST_DS_MODE] = ds_mode_q;
		status_word[QIM_ST_FORCE] = force_strap_s;
		status_word[QIM_ST_DEPTH] = depth_strap_s;
		status_word[QIM_ST_REQ_LSB +: QIM_NCH] = chan_req;
		status_word[QIM_ST_DEEP_LSB +: QIM_NCH] = depth128_q;
	end

	always_comb begin
		rd_word = '0;
		rd_ok = 1'b1;
		if (s_axi_araddr == QIM_OFS_CTRL) begin
			rd_word = {20'h00000, ctrl_q};
		end else if (s_axi_araddr == QIM_OFS_FIFOCTL) begin
			rd_word = {28'h0000000, deep_q};
		end else if (s_axi_araddr == QIM_OFS_SRCEN) begin
			rd_word = {16'h0000, srcen_q};
		end else if (s_axi_araddr == QIM_OFS_STATUS) begin
			rd_word = status_word;
		end else if (s_axi_araddr == QIM_OFS_INTSTAT) begin
			rd_word = {27'h0000000, stat_q};
		end else if (s_axi_araddr == QIM_OFS_INTMASK) begin
			rd_word = {27'h0000000, mask_q};
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= QIM_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_ok ? QIM_RESP_OKAY : QIM_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	AST_OWN_REQ_ONLY: assert property (@(posedge mclk) disable iff (!rstn)
		ce |=> chan_irq_out == $past(chan_req))
		else $error("Channel output does not follow its own request.");

	AST_OE_OFF_AFTER_RESET: assert property (@(posedge mclk)
		$rose(rstn) |-> chan_irq_oe == 4'h0 && !shared_irq_oe)
		else $error("Interrupt outputs enabled at reset release.");

	AST_OE_BY_MCR: assert property (@(posedge mclk) disable iff (!rstn)
		ce && !ds_mode && !force_strap_s |=> chan_irq_oe == $past(modem_ctrl_irq_out_enable))
		else $error("Output enable does not follow the modem control bit.");

	AST_OE_FORCED: assert property (@(posedge mclk) disable iff (!rstn)
		ce && !ds_mode && force_strap_s |=> chan_irq_oe == 4'hf)
		else $error("Forced strap did not enable all outputs.");

	AST_DS_IGNORES_STRAP: assert property (@(posedge mclk) disable iff (!rstn)
		ce && ds_mode |=> chan_irq_oe == 4'h0)
		else $error("Per-channel outputs enabled in data-strobe mode.");

	AST_SHARED_LINE: assert property (@(posedge mclk) disable iff (!rstn)
		ce |=> shared_irq_oe == ($past(ds_mode) && $past(|chan_req)) && !shared_irq_n_out)
		else $error("Shared line does not reflect the merged requests.");

	AST_MODE_FROM_STRAP: assert property (@(posedge mclk) disable iff (!rstn)
		ce ##1 ce |=> ds_mode == !$past(bus_strap_s))
		else $error("Bus mode does not follow the strap.");

	AST_DEPTH_STRAP: assert property (@(posedge mclk) disable iff (!rstn)
		ce && !deep_q[0] && !enh_mode[0] |=> fifo_depth_128[0] == !$past(depth_strap_s))
		else $error("FIFO depth does not follow the strap.");

	AST_STRAP_READ: assert property (@(posedge mclk) disable iff (!rstn)
		ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == QIM_OFS_STATUS
		|=> s_axi_rvalid && s_axi_rdata[QIM_ST_DEPTH] == $past(depth_strap_s))
		else $error("Status read does not return the live depth strap.");

	AST_DEEP_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
		do_wr && sel_fifo && w_strb_q[0] && w_data_q[0] && line_ctrl_divisor_latch_access[0]
		|=> deep_q[0] ##1 (!ce || fifo_depth_128[0]))
		else $error("Deep-select write did not force 128 entries.");

	AST_REQ_FROM_SOURCES: assert property (@(posedge mclk) disable iff (!rstn)
		chan_req[1] == |(chan_src_pend[7:4] & srcen_q[7:4]))
		else $error("Channel request does not match enabled pending sources.");
endmodule : qim_irq_mode
`default_nettype wire

/* test/qim_host_model.sv */
// Host side of the interrupt pins: resolves the three-state and open-drain lines.
`timescale 1ns/1ns
`default_nettype none
module qim_host_model
	import qim_pkg::*;
(
	input wire logic mclk,
	input wire logic [qim_pkg::QIM_NCH-1:0] chan_irq_out,
	input wire logic [qim_pkg::QIM_NCH-1:0] chan_irq_oe,
	input wire logic shared_irq_n_out,
	input wire logic shared_irq_oe,
	output logic [qim_pkg::QIM_NCH-1:0] host_int_lvl,
	output logic host_irq_n
);
	logic [qim_pkg::QIM_NCH-1:0] last_q;

	// An undriven line has no pull, so the model shows the inverse of its last driven level.
	always_ff @(posedge mclk) begin
		for (int c = 0; c < QIM_NCH; c++) begin
			if (chan_irq_oe[c]) begin
				last_q[c] <= chan_irq_out[c];
			end
		end
	end
	always_comb begin
		for (int c = 0; c < QIM_NCH; c++) begin
			host_int_lvl[c] = chan_irq_oe[c] ? chan_irq_out[c] : ~last_q[c];
		end
	end
	// The shared line has a pull-up on the host board.
	assign host_irq_n = shared_irq_oe ? shared_irq_n_out : 1'b1;
endmodule : qim_host_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the interrupt routing and mode select block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import qim_pkg::*;
	logic mclk, rstn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, chan_irq_out, chan_irq_oe, fifo_depth_128, host_int_lvl;
	logic [1:0] bresp, rresp;
	logic [15:0] pend;
	logic bus_mode_strap, force_strap, depth_strap, shared_irq_n_out, shared_irq_oe;
	logic ds_mode, irq, host_irq_n;
	logic [1:0] resp;
	int n_errors = 0;
	int check_count = 0;

	qim_irq_mode i_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .chan_src_pend(pend), .bus_mode_strap(bus_mode_strap),
		.irq_force_enable_strap(force_strap), .fifo_depth_strap(depth_strap),
		.chan_irq_out(chan_irq_out), .chan_irq_oe(chan_irq_oe),
		.shared_irq_n_out(shared_irq_n_out), .shared_irq_oe(shared_irq_oe),
		.fifo_depth_128(fifo_depth_128), .ds_mode(ds_mode), .irq(irq));
	qim_host_model i_host (.mclk(mclk), .chan_irq_out(chan_irq_out), .chan_irq_oe(chan_irq_oe),
		.shared_irq_n_out(shared_irq_n_out), .shared_irq_oe(shared_irq_oe),
		.host_int_lvl(host_int_lvl), .host_irq_n(host_irq_n));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// Each channel is judged at the rising edge on the values that edge samples.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_open, w_open;
		aw_open = 1'b1;
		w_open = 1'b1;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (aw_open && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_open = 1'b0;
			end
			if (w_open && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_open = 1'b0;
			end
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ar_open;
		ar_open = 1'b1;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (ar_open && arready === 1'b1) begin
				arvalid <= 1'b0;
				ar_open = 1'b0;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d & m, e, "register read");
	endtask : rd_chk

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : settle

	task automatic t_reset;
		chk(chan_irq_oe, 4'h0, "oe after reset");
		rd_chk(QIM_OFS_CTRL, 32'hffffffff, 32'h0);
		rd_chk(QIM_OFS_SRCEN, 32'hffffffff, 32'h0);
		rd_chk(8'h40, 32'hffffffff, 32'h0);
		chk(resp, QIM_RESP_SLVERR, "unmapped read");
		wr(8'h40, 32'h0);
		chk(resp, QIM_RESP_SLVERR, "unmapped write");
	endtask : t_reset

	task automatic t_separate;
		pend <= 16'h0100;
		settle(3);
		rd_chk(QIM_OFS_STATUS, 32'hf0, 32'h00);
		wr(QIM_OFS_SRCEN, 32'h0100);
		settle(3);
		rd_chk(QIM_OFS_STATUS, 32'hf1, 32'h40);
		chk(chan_irq_out, 4'b0100, "own request only");
		chk(chan_irq_oe, 4'h0, "oe bit clear");
		wr(QIM_OFS_CTRL, 32'h4);
		settle(3);
		chk(chan_irq_oe, 4'b0100, "oe by bit");
		chk(host_int_lvl[2], 1'b1, "line driven high");
		@(posedge mclk);
		rstn <= 1'b0;
		settle(1);
		chk(chan_irq_oe, 4'h0, "oe cleared by reset");
		@(posedge mclk);
		rstn <= 1'b1;
		settle(3);
		chk(chan_irq_oe, 4'h0, "oe off after reset");
		wr(QIM_OFS_SRCEN, 32'h0100);
		chk(resp, QIM_RESP_OKAY, "write answer");
		force_strap <= 1'b1;
		settle(6);
		chk(chan_irq_oe, 4'hf, "forced enable");
		chk(host_int_lvl, 4'b0100, "lines per channel");
		force_strap <= 1'b0;
		wr(QIM_OFS_CTRL, 32'h0);
		settle(6);
		chk(chan_irq_oe, 4'h0, "oe removed");
	endtask : t_separate

	task automatic t_dstrobe;
		bus_mode_strap <= 1'b0;
		pend <= 16'h0000;
		settle(6);
		chk(ds_mode, 1'b1, "data-strobe mode");
		chk(host_irq_n, 1'b1, "shared line floats");
		wr(QIM_OFS_SRCEN, 32'hffff);
		pend <= 16'h2000;
		settle(3);
		chk(host_irq_n, 1'b0, "shared line low");
		chk(shared_irq_oe, 1'b1, "shared line driven");
		force_strap <= 1'b1;
		pend <= 16'h0001;
		settle(6);
		chk(host_irq_n, 1'b0, "other channel merged");
		chk(chan_irq_oe, 4'h0, "strap ignored");
		pend <= 16'h0000;
		settle(3);
		chk(shared_irq_oe, 1'b0, "shared line released");
		force_strap <= 1'b0;
		bus_mode_strap <= 1'b1;
		settle(6);
		chk(ds_mode, 1'b0, "separate-strobe mode");
	endtask : t_dstrobe

	task automatic t_fifo;
		settle(1);
		chk(fifo_depth_128, 4'h0, "depth 16");
		rd_chk(QIM_OFS_STATUS, 32'h4, 32'h4);
		wr(QIM_OFS_INTSTAT, 32'h1f);
		wr(QIM_OFS_INTMASK, 32'h10);
		chk(irq, 1'b0, "irq idle");
		depth_strap <= 1'b0;
		settle(6);
		chk(fifo_depth_128, 4'hf, "depth 128");
		rd_chk(QIM_OFS_STATUS, 32'h4, 32'h0);
		chk(irq, 1'b1, "strap event irq");
		wr(QIM_OFS_INTMASK, 32'h0f);
		chk(irq, 1'b0, "masked irq");
		wr(QIM_OFS_INTMASK, 32'h10);
		wr(QIM_OFS_INTSTAT, 32'h10);
		chk(irq, 1'b0, "cleared irq");
		depth_strap <= 1'b1;
		wr(QIM_OFS_FIFOCTL, 32'h2);
		settle(6);
		chk(fifo_depth_128, 4'h0, "no write without access bit");
		wr(QIM_OFS_CTRL, 32'h20);
		wr(QIM_OFS_FIFOCTL, 32'h2);
		settle(3);
		chk(fifo_depth_128, 4'b0010, "deep select override");
		wr(QIM_OFS_CTRL, 32'h800);
		settle(3);
		chk(fifo_depth_128, 4'b1010, "enhanced mode override");
	endtask : t_fifo

	task automatic stop_test;
		if (n_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		pend = 16'h0000;
		bus_mode_strap = 1'b1;
		force_strap = 1'b0;
		depth_strap = 1'b1;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		@(negedge mclk);
		t_reset();
		t_separate();
		t_dstrobe();
		t_fifo();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
